// file: design/ifs_pkg.sv
// Package: register map, field positions and reset values of the interrupt flag block
package ifs_pkg;
  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] IFS_OFF_FLAG   = 12'h000;
  localparam logic [11:0] IFS_OFF_MASK   = 12'h004;
  localparam logic [11:0] IFS_OFF_STATUS = 12'h008;
  localparam logic [11:0] IFS_OFF_IMASK  = 12'h00C;
  // ****************************************************************
  // Flag bit positions
  // ****************************************************************
  localparam int IFS_BIT_EXT0  = 0;
  localparam int IFS_BIT_CAP1  = 1;
  localparam int IFS_BIT_CMP1  = 2;
  localparam int IFS_BIT_TMR1  = 3;
  localparam int IFS_BIT_CAP2  = 5;
  localparam int IFS_BIT_CMP2  = 6;
  localparam int IFS_BIT_TMR2  = 7;
  localparam int IFS_BIT_TMR3  = 8;
  localparam int IFS_BIT_SPIF  = 9;
  localparam int IFS_BIT_SPIE  = 10;
  localparam int IFS_BIT_URX   = 11;
  localparam int IFS_BIT_UTX   = 12;
  localparam int IFS_BIT_ADC   = 13;
  localparam int IFS_WIDTH     = 16;
  // Implemented bits: 15, 14 and 4 read zero
  localparam logic [15:0] IFS_IMPL_MASK = 16'h3FEF;
  localparam logic [15:0] IFS_RESET     = 16'h0000;
  localparam logic [1:0]  IFS_EVT_WIDTH = 2'd2;
  // Block event status bits (sticky, write one to clear)
  localparam int IFS_EVT_RAISE = 0;
  localparam int IFS_EVT_OVER  = 1;
  localparam logic [1:0]  IFS_EVT_RESET = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0]  HTRANS_SEQ    = 2'b11;
  typedef enum logic [1:0] {
    IFS_ST_IDLE  = 2'b00,
    IFS_ST_WRITE = 2'b01,
    IFS_ST_READ  = 2'b11
  } ifs_phase_t;
endpackage : ifs_pkg

// file: design/ifs_flag_bit.sv
// One interrupt request flag with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
module ifs_flag_bit (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic set_req,
  input  wire logic wr_en,
  input  wire logic wr_val,
  output var  logic flag
);
  // Source request wins over a software write of zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag <= 1'b0; // R6
    end else if (set_req) begin
      flag <= 1'b1; // R1
    end else if (wr_en) begin
      flag <= wr_val; // R2
    end
  end
endmodule : ifs_flag_bit
`default_nettype wire

// file: design/ifs_ahb_slave.sv
// AHB-Lite slave front end: captures the address phase and holds it through wait states
`timescale 1ns/1ps
`default_nettype none
module ifs_ahb_slave
  import ifs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  output var  logic        wr_pend,
  output var  logic        rd_pend,
  output var  logic [11:0] acc_addr
);
  wire logic take = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  // Register the address phase for use in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend  <= 1'b0;
      rd_pend  <= 1'b0;
      acc_addr <= 12'h000;
    end else if (hready) begin
      wr_pend  <= take & hwrite;
      rd_pend  <= take & ~hwrite;
      acc_addr <= take ? haddr[11:0] : acc_addr;
    end
  end
endmodule : ifs_ahb_slave
`default_nettype wire

// file: design/ifs_flag_bank.sv
// Interrupt flag status bank 0 with AHB-Lite register access
//
// Contract
// R1 - Each flag reads one once its source raised an uncleared request.
// R2 - A flag reads zero while no request from its source is pending. The code also sets a flag when software writes one to it.
// R3 - Bit 1 holds the capture channel one flag.
// R4 - Bit 0 holds the external interrupt zero flag.
// R5 - Bits 15, 14 and 4 read zero and ignore writes.
// R6 - Every reset clears all flags to one reset value.
// R7 - Bits 13..5,3,2: adc, uart tx, uart rx, spi, spi fault, timers, compare, capture.
`timescale 1ns/1ps
`default_nettype none
module ifs_flag_bank
  import ifs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        adc_done_req,
  input  wire logic        uart_one_tx_req,
  input  wire logic        uart_one_rx_req,
  input  wire logic        spi_one_event_req,
  input  wire logic        spi_one_fault_req,
  input  wire logic        timer_three_req,
  input  wire logic        timer_two_req,
  input  wire logic        compare_two_req,
  input  wire logic        capture_two_req,
  input  wire logic        timer_one_req,
  input  wire logic        compare_one_req,
  input  wire logic        capture_one_req,
  input  wire logic        external_int_zero_req,
  output var  logic [15:0] irq_pending,
  output var  logic        irq
);
  import ifs_pkg::*;

  // ****************************************************************
  // Bus front end
  // ****************************************************************
  logic        wr_pend;
  logic        rd_pend;
  logic [11:0] acc_addr;

  ifs_ahb_slave u_slave (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .hsel     (hsel),
    .haddr    (haddr),
    .htrans   (htrans),
    .hwrite   (hwrite),
    .hready   (hready),
    .wr_pend  (wr_pend),
    .rd_pend  (rd_pend),
    .acc_addr (acc_addr)
  );

  // Address decode
  wire logic hit_flag   = (acc_addr == IFS_OFF_FLAG);
  wire logic hit_mask   = (acc_addr == IFS_OFF_MASK);
  wire logic hit_status = (acc_addr == IFS_OFF_STATUS);
  wire logic hit_imask  = (acc_addr == IFS_OFF_IMASK);
  wire logic wr_flag    = wr_pend & hit_flag;
  wire logic wr_mask    = wr_pend & hit_mask;
  wire logic wr_status  = wr_pend & hit_status;
  wire logic wr_imask   = wr_pend & hit_imask;
  // A read gets one wait state: read data is loaded in the first data-phase
  // cycle, so a write of the previous transfer has landed before it is read
  wire logic rd_take    = hsel & hready & htrans[1] & ~hwrite;

  // ****************************************************************
  // Source request vector
  // ****************************************************************
  logic [15:0] src_req;
  always_comb begin
    src_req                = 16'h0000;
    src_req[IFS_BIT_EXT0]  = external_int_zero_req; // R4
    src_req[IFS_BIT_CAP1]  = capture_one_req; // R3
    src_req[IFS_BIT_CMP1]  = compare_one_req; // R7
    src_req[IFS_BIT_TMR1]  = timer_one_req; // R7
    src_req[IFS_BIT_CAP2]  = capture_two_req; // R7
    src_req[IFS_BIT_CMP2]  = compare_two_req; // R7
    src_req[IFS_BIT_TMR2]  = timer_two_req; // R7
    src_req[IFS_BIT_TMR3]  = timer_three_req; // R7
    src_req[IFS_BIT_SPIF]  = spi_one_fault_req; // R7
    src_req[IFS_BIT_SPIE]  = spi_one_event_req; // R7
    src_req[IFS_BIT_URX]   = uart_one_rx_req; // R7
    src_req[IFS_BIT_UTX]   = uart_one_tx_req; // R7
    src_req[IFS_BIT_ADC]   = adc_done_req; // R7
  end

  // ****************************************************************
  // Flag storage
  // ****************************************************************
  logic [15:0] interrupt_flag_status_0;

  // One flag per implemented bit; the rest are constant zero
  genvar gi;
  generate
    for (gi = 0; gi < IFS_WIDTH; gi++) begin : g_flag
      if (IFS_IMPL_MASK[gi]) begin : g_impl
        ifs_flag_bit u_bit (
          .hclk    (hclk),
          .hresetn (hresetn),
          .set_req (src_req[gi]),
          .wr_en   (wr_flag),
          .wr_val  (hwdata[gi]),
          .flag    (interrupt_flag_status_0[gi])
        );
      end else begin : g_unimpl
        assign interrupt_flag_status_0[gi] = 1'b0; // R5
      end
    end
  endgenerate

  // ****************************************************************
  // Interrupt enable and block event registers
  // ****************************************************************
  logic [15:0] flag_mask;
  logic [1:0]  evt_status;
  logic [1:0]  evt_imask;
  logic [15:0] prev_flags;

  // Rising edge of any flag enabled in flag_mask raises the block event
  wire logic [15:0] new_flags  = interrupt_flag_status_0 & ~prev_flags;
  wire logic        ev_raise   = |(new_flags & flag_mask);
  wire logic        ev_over    = |(src_req & interrupt_flag_status_0 & IFS_IMPL_MASK);
  wire logic [1:0]  ev_set     = {ev_over, ev_raise};
  wire logic [1:0]  ev_clr     = wr_status ? hwdata[1:0] : 2'b00;
  wire logic [1:0]  next_evt   = ev_set | (evt_status & ~ev_clr);

  // Mask, event status (set beats write-one-clear) and flag history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_mask  <= 16'h0000;
      evt_imask  <= IFS_EVT_RESET;
      evt_status <= IFS_EVT_RESET;
      prev_flags <= IFS_RESET;
    end else begin
      flag_mask  <= wr_mask ? (hwdata[15:0] & IFS_IMPL_MASK) : flag_mask;
      evt_imask  <= wr_imask ? hwdata[1:0] : evt_imask;
      evt_status <= next_evt;
      prev_flags <= interrupt_flag_status_0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  wire logic [31:0] rd_mux =
    hit_flag   ? {16'h0000, interrupt_flag_status_0} :
    hit_mask   ? {16'h0000, flag_mask} :
    hit_status ? {30'h0000_0000, evt_status} :
    hit_imask  ? {30'h0000_0000, evt_imask} : 32'h0000_0000;

  // Read data, pending vector and interrupt line all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata      <= 32'h0000_0000;
      irq_pending <= 16'h0000;
      irq         <= 1'b0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      hrdata      <= rd_mux;
      irq_pending <= interrupt_flag_status_0 & flag_mask;
      irq         <= |(next_evt & evt_imask);
      hreadyout   <= ~rd_take;
      hresp       <= 1'b0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    (interrupt_flag_status_0 & ~IFS_IMPL_MASK) == 16'h0000)
    else $error("reserved flag bit set");
  a_set_flag_cap1: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    capture_one_req |=> interrupt_flag_status_0[IFS_BIT_CAP1])
    else $error("capture one flag not set");
  a_set_flag_ext0: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    external_int_zero_req |=> interrupt_flag_status_0[IFS_BIT_EXT0])
    else $error("external zero flag not set");
  a_set_flag_adc: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    adc_done_req |=> interrupt_flag_status_0[IFS_BIT_ADC])
    else $error("adc flag not set");
  a_flag_holds: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (interrupt_flag_status_0[IFS_BIT_TMR1] && !wr_flag) |=> interrupt_flag_status_0[IFS_BIT_TMR1])
    else $error("flag lost without clear");
  a_flag_clears: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    (wr_flag && !hwdata[IFS_BIT_URX] && !uart_one_rx_req) |=> !interrupt_flag_status_0[IFS_BIT_URX])
    else $error("flag did not clear");
  a_no_spurious: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    (!interrupt_flag_status_0[IFS_BIT_TMR2] && !timer_two_req && !wr_flag)
      |=> !interrupt_flag_status_0[IFS_BIT_TMR2])
    else $error("flag set without request");
  a_read_flags: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (rd_pend && hit_flag) |=> hrdata[15:0] == $past(interrupt_flag_status_0))
    else $error("read data differs from flags");
  a_reset_value: assert property (@(posedge hclk) // R6
    $rose(hresetn) |-> interrupt_flag_status_0 == IFS_RESET)
    else $error("flags not cleared by reset");

  // ****************************************************************
  // Per-source flag checks
  // ****************************************************************
  // Every source sets its own flag on the edge after its request
  a_set_flag_cmp1: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    compare_one_req |=> interrupt_flag_status_0[IFS_BIT_CMP1])
    else $error("compare one flag not set");
  a_set_flag_tmr1: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    timer_one_req |=> interrupt_flag_status_0[IFS_BIT_TMR1])
    else $error("timer one flag not set");
  a_set_flag_cap2: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    capture_two_req |=> interrupt_flag_status_0[IFS_BIT_CAP2])
    else $error("capture two flag not set");
  a_set_flag_cmp2: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    compare_two_req |=> interrupt_flag_status_0[IFS_BIT_CMP2])
    else $error("compare two flag not set");
  a_set_flag_tmr2: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    timer_two_req |=> interrupt_flag_status_0[IFS_BIT_TMR2])
    else $error("timer two flag not set");
  a_set_flag_tmr3: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    timer_three_req |=> interrupt_flag_status_0[IFS_BIT_TMR3])
    else $error("timer three flag not set");
  a_set_flag_spif: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    spi_one_fault_req |=> interrupt_flag_status_0[IFS_BIT_SPIF])
    else $error("spi fault flag not set");
  a_set_flag_spie: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    spi_one_event_req |=> interrupt_flag_status_0[IFS_BIT_SPIE])
    else $error("spi event flag not set");
  a_set_flag_urx: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    uart_one_rx_req |=> interrupt_flag_status_0[IFS_BIT_URX])
    else $error("uart rx flag not set");
  a_set_flag_utx: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    uart_one_tx_req |=> interrupt_flag_status_0[IFS_BIT_UTX])
    else $error("uart tx flag not set");

  // ****************************************************************
  // Whole-register flag checks
  // ****************************************************************
  // Low half of the write data, as seen by the flag register
  wire logic [15:0] wr_word = hwdata[15:0];

  // A flag only falls through a software write
  a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    !wr_flag |=> (($past(interrupt_flag_status_0) & ~interrupt_flag_status_0) == 16'h0000))
    else $error("flag fell without a write");
  // A flag only rises through its own request when software is not writing
  a_flag_no_rise: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    !wr_flag |=> ((interrupt_flag_status_0 & ~$past(interrupt_flag_status_0) & ~$past(src_req)) == 16'h0000))
    else $error("flag rose without a request");
  // A written value lands, a same-cycle request still wins for its bit
  a_flag_write: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    wr_flag |=> interrupt_flag_status_0 == (($past(wr_word) | $past(src_req)) & IFS_IMPL_MASK))
    else $error("written flag value lost");

  // Mask keeps reserved bits clear; pending vector is flags under mask
  a_mask_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    (flag_mask & ~IFS_IMPL_MASK) == 16'h0000)
    else $error("reserved mask bit set");
  a_pending_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_pending == ($past(interrupt_flag_status_0) & $past(flag_mask)))
    else $error("pending vector differs from flags");

  // ****************************************************************
  // Bus answer checks
  // ****************************************************************
  // Reads wait exactly one cycle, writes none, the response is always okay
  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_take |=> !hreadyout)
    else $error("read not stretched");
  a_wait_one: assert property (@(posedge hclk) disable iff (!hresetn)
    !hreadyout |=> hreadyout)
    else $error("wait state too long");
  a_write_ready: assert property (@(posedge hclk) disable iff (!hresetn)
    (hsel && hready && htrans[1] && hwrite) |=> hreadyout)
    else $error("write stretched");
  a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    !hresp)
    else $error("error response on bus");
  // Every register is at most sixteen bits wide
  a_rdata_upper: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");

  // ****************************************************************
  // Block event checks
  // ****************************************************************
  // Event bits are set by their events and held until cleared
  a_event_raise: assert property (@(posedge hclk) disable iff (!hresetn)
    ev_raise |=> evt_status[IFS_EVT_RAISE])
    else $error("raise event lost");
  a_event_over: assert property (@(posedge hclk) disable iff (!hresetn)
    ev_over |=> evt_status[IFS_EVT_OVER])
    else $error("overrun event lost");
  a_event_held: assert property (@(posedge hclk) disable iff (!hresetn)
    (evt_status[IFS_EVT_RAISE] && !ev_clr[IFS_EVT_RAISE]) |=> evt_status[IFS_EVT_RAISE])
    else $error("raise event lost without clear");
  // The interrupt line follows the event bits in the same cycle, under the previous cycle's enables
  a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(evt_status & $past(evt_imask)))
    else $error("interrupt line differs from events");
endmodule : ifs_flag_bank
`default_nettype wire

// file: tb/ifs_flag_bank_test.sv
// Self-checking testbench for the interrupt flag bank reached over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module ifs_flag_bank_test;
  import ifs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [12:0] req;
  logic [15:0] irq_pending;
  int          err_total, n_compared;
  int          bit_of [13] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13};

  // The single slave drives the bus ready
  assign hready = hreadyout;

  ifs_flag_bank dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .adc_done_req(req[12]), .uart_one_tx_req(req[11]), .uart_one_rx_req(req[10]),
    .spi_one_event_req(req[9]), .spi_one_fault_req(req[8]), .timer_three_req(req[7]),
    .timer_two_req(req[6]), .compare_two_req(req[5]), .capture_two_req(req[4]),
    .timer_one_req(req[3]), .compare_one_req(req[2]), .capture_one_req(req[1]),
    .external_int_zero_req(req[0]), .irq_pending(irq_pending), .irq(irq)
  );

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic complete_run();
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Waits for an edge with hready high; a stuck bus ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_total++;
        complete_run();
      end
      @(posedge hclk);
    end
  endtask

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rdv);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, addr};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wr ? wd : 32'h0000_0000;
    wait_ready();
    rdv = hrdata;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, addr, wd, dummy);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, addr, 32'h0000_0000, v);
    chk(name, exp, v);
  endtask

  // Raises the given requests for one cycle
  task automatic pulse(input logic [12:0] v);
    req <= v;
    @(posedge hclk);
    req <= 13'h0000;
  endtask

  // Bounded wait for the interrupt line to reach a level
  task automatic wait_irq(input logic exp);
    for (int n = 0; n < 10 && irq !== exp; n++) @(posedge hclk);
    chk("irq", 32'(exp), 32'(irq));
    if (irq !== exp) complete_run();
  endtask

  // ****************************************************************
  // Clock and main sequence
  // ****************************************************************
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; req = '0; err_total = 0; n_compared = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a < 4; a++) rd_chk("reset value", 12'(a * 4), 32'h0000_0000);
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    // Each source sets its own bit and software clears it
    for (int k = 0; k < 13; k++) begin
      pulse(13'(1 << k));
      rd_chk("flag set", IFS_OFF_FLAG, 32'(1) << bit_of[k]);
      wr(IFS_OFF_FLAG, 32'h0000_0000);
      rd_chk("flag clear", IFS_OFF_FLAG, 32'h0000_0000);
    end
    // Unimplemented bits and an unmapped address
    wr(IFS_OFF_FLAG, 32'hFFFF_FFFF);
    rd_chk("flag all ones", IFS_OFF_FLAG, 32'h0000_3FEF);
    wr(IFS_OFF_FLAG, 32'h0000_0000);
    wr(12'h010, 32'hFFFF_FFFF);
    rd_chk("unmapped", 12'h010, 32'h0000_0000);
    rd_chk("flag after unmapped", IFS_OFF_FLAG, 32'h0000_0000);
    // Interrupt raised, masked, unmasked and cleared
    wr(IFS_OFF_MASK, 32'h0000_0001);
    wr(IFS_OFF_IMASK, 32'h0000_0001);
    pulse(13'h0001);
    rd_chk("event status", IFS_OFF_STATUS, 32'h0000_0001);
    chk("irq pending", 32'h0000_0001, {16'h0000, irq_pending});
    wait_irq(1'b1);
    wr(IFS_OFF_IMASK, 32'h0000_0000);
    wait_irq(1'b0);
    wr(IFS_OFF_IMASK, 32'h0000_0003);
    wait_irq(1'b1);
    wr(IFS_OFF_STATUS, 32'h0000_0001);
    wait_irq(1'b0);
    pulse(13'h0001);
    rd_chk("repeat event", IFS_OFF_STATUS, 32'h0000_0002);
    wait_irq(1'b1);
    wr(IFS_OFF_STATUS, 32'h0000_0003);
    rd_chk("status cleared", IFS_OFF_STATUS, 32'h0000_0000);
    // Reset in mid-run clears every flag
    pulse(13'h1FFF);
    rd_chk("all flags", IFS_OFF_FLAG, 32'h0000_3FEF);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("flags after reset", IFS_OFF_FLAG, 32'h0000_0000);
    rd_chk("mask after reset", IFS_OFF_MASK, 32'h0000_0000);
    wait_irq(1'b0);
    complete_run();
  end
endmodule // ifs_flag_bank_test
`default_nettype wire
